// File: pmt_timer.v
// Three eight-bit period-match timers with AHB-Lite register access
//
// Contract
// - Three independent identical eight-bit timer instances
// - Timers tick only from instruction clock
// - Count starts at zero, increments per tick
// - Prescaler offers divide by 1, 4, 16
// - Match pulses; count clears on next increment
// - Reset clears count, period becomes all ones
// - Count or control write clears scalers
// - Control write keeps count value
// - Flag after postscale field plus one matches
// - Latched flag; request gated by enable, priority
// - Unscaled match offered as PWM time base
// - First timer clocks serial port in SPI mode
// - Sleep halts counting, registers hold values
// - Module disable holds reset, gates clock
// - Count and period readable and writable
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pmt_defs.vh"

module pmt_timer #(
    parameter NUM_TIMERS = 3,
    parameter CCP_UNITS = 5
)(
    input wire clk,
    input wire reset,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [2*CCP_UNITS-1:0] timebase_select,
    output reg [CCP_UNITS-1:0] ccp_timebase,
    output wire serial_shift_clock,
    output wire irq,
    output wire irq_high,
    output wire irq_low
);

// ------------------------------------------------------------
// Helpers
// ------------------------------------------------------------
function [3:0] pre_last;
    input [1:0] sel;
    begin
        if (sel[1])
            pre_last = `PMT_PRE_DIV16_LAST;
        else if (sel[0])
            pre_last = `PMT_PRE_DIV4_LAST;
        else
            pre_last = 4'h0;
    end
endfunction

// Byte address of an instance's register group
function [7:0] inst_base;
    input integer idx;
    reg [31:0] full;
    begin
        full = idx * `PMT_INST_STRIDE;
        inst_base = full[7:0];
    end
endfunction

function is_reg;
    input [7:0] addr;
    input [7:0] off;
    begin
        is_reg = (addr == off);
    end
endfunction

// ------------------------------------------------------------
// Bus slave: one address phase captured, zero-wait data phase
// ------------------------------------------------------------
reg wr_pend;
reg rd_pend;
reg [7:0] acc_addr;
wire addr_ok = hsel && hready && htrans[1];

assign hreadyout = 1'b1;
assign hresp = 1'b0;

always @(posedge clk or posedge reset)
begin
    if (reset)
    begin
        wr_pend <= 1'b0;
        rd_pend <= 1'b0;
        acc_addr <= 8'h00;
    end
    else
    begin
        wr_pend <= addr_ok && hwrite;
        rd_pend <= addr_ok && !hwrite;
        if (addr_ok)
            acc_addr <= haddr[7:0];
    end
end

wire [7:0] wdat = hwdata[7:0];

// ------------------------------------------------------------
// Shared registers
// ------------------------------------------------------------
reg [NUM_TIMERS-1:0] match_irq_flag;
reg [NUM_TIMERS-1:0] match_irq_enable;
reg [NUM_TIMERS-1:0] match_irq_priority;
reg [NUM_TIMERS-1:0] module_disable;
reg [7:0] sys_ctrl;
reg [1:0] instr_div;

wire wr_mask = wr_pend && is_reg(acc_addr, `PMT_OFF_MASK);
wire wr_prio = wr_pend && is_reg(acc_addr, `PMT_OFF_PRIORITY);
wire wr_dis = wr_pend && is_reg(acc_addr, `PMT_OFF_DISABLE);
wire wr_sys = wr_pend && is_reg(acc_addr, `PMT_OFF_SYSCTL);
wire rd_status = rd_pend && is_reg(acc_addr, `PMT_OFF_STATUS);
wire sleeping = sys_ctrl[`PMT_SYS_SLEEP_BIT];

// Instruction clock enable: one pulse every fourth system clock
wire instr_tick = (instr_div == `PMT_INSTR_DIV);

always @(posedge clk or posedge reset)
begin
    if (reset)
        instr_div <= 2'h0;
    else
        instr_div <= instr_div + 2'h1;
end

// Interrupt enable mask
always @(posedge clk or posedge reset)
begin
    if (reset)
        match_irq_enable <= {NUM_TIMERS{1'b0}};
    else if (wr_mask)
        match_irq_enable <= wdat[NUM_TIMERS-1:0];
end

// Interrupt priority select
always @(posedge clk or posedge reset)
begin
    if (reset)
        match_irq_priority <= {NUM_TIMERS{1'b0}};
    else if (wr_prio)
        match_irq_priority <= wdat[NUM_TIMERS-1:0];
end

// Per-timer module disable
always @(posedge clk or posedge reset)
begin
    if (reset)
        module_disable <= {NUM_TIMERS{1'b0}};
    else if (wr_dis)
        module_disable <= wdat[NUM_TIMERS-1:0];
end

// Sleep bit and serial port mode
always @(posedge clk or posedge reset)
begin
    if (reset)
        sys_ctrl <= 8'h00;
    else if (wr_sys)
        sys_ctrl <= wdat;
end

// ------------------------------------------------------------
// Timer instances
// ------------------------------------------------------------
reg [7:0] count_value [0:NUM_TIMERS-1];
reg [7:0] period_value [0:NUM_TIMERS-1];
reg [7:0] timer_control [0:NUM_TIMERS-1];
reg [3:0] pre_cnt [0:NUM_TIMERS-1];
reg [3:0] post_cnt [0:NUM_TIMERS-1];
reg [NUM_TIMERS-1:0] match_pulse;
reg [NUM_TIMERS-1:0] clear_pending;
wire [NUM_TIMERS-1:0] post_event;

genvar gi;
generate
for (gi = 0; gi < NUM_TIMERS; gi = gi + 1)
begin : g_tmr
    wire [7:0] base = inst_base(gi);
    wire wr_cnt = wr_pend && is_reg(acc_addr, base + `PMT_OFF_COUNT);
    wire wr_per = wr_pend && is_reg(acc_addr, base + `PMT_OFF_PERIOD);
    wire wr_ctl = wr_pend && is_reg(acc_addr, base + `PMT_OFF_CONTROL);
    wire run = timer_control[gi][`PMT_RUN_BIT];
    wire dis = module_disable[gi];
    // Clock is gated by sleep and by module disable
    wire tick = instr_tick && !sleeping && !dis && run;
    wire pre_done = (pre_cnt[gi] >= pre_last(timer_control[gi][`PMT_CKPS_MSB:`PMT_CKPS_LSB]));
    wire inc = tick && pre_done;
    wire is_match = (count_value[gi] == period_value[gi]);
    wire post_done = (post_cnt[gi] == timer_control[gi][`PMT_OUTPS_MSB:`PMT_OUTPS_LSB]);
    assign post_event[gi] = match_pulse[gi] && post_done;

    // Period and control registers
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            period_value[gi] <= `PMT_PERIOD_RESET;
            timer_control[gi] <= `PMT_CONTROL_RESET;
        end
        else if (dis)
        begin
            // Held in reset while disabled
            period_value[gi] <= `PMT_PERIOD_RESET;
            timer_control[gi] <= `PMT_CONTROL_RESET;
        end
        else
        begin
            if (wr_per)
                period_value[gi] <= wdat;
            if (wr_ctl)
                timer_control[gi] <= wdat & `PMT_CTRL_MASK;
        end
    end

    // Prescaler and postscaler counters
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pre_cnt[gi] <= 4'h0;
            post_cnt[gi] <= 4'h0;
        end
        else if (dis)
        begin
            pre_cnt[gi] <= 4'h0;
            post_cnt[gi] <= 4'h0;
        end
        else if (wr_cnt || wr_ctl)
        begin
            pre_cnt[gi] <= 4'h0;
            post_cnt[gi] <= 4'h0;
        end
        else
        begin
            if (tick)
                pre_cnt[gi] <= pre_done ? 4'h0 : pre_cnt[gi] + 4'h1;
            if (post_event[gi])
                post_cnt[gi] <= 4'h0;
            else if (match_pulse[gi])
                post_cnt[gi] <= post_cnt[gi] + 4'h1;
        end
    end

    // Count register, match pulse and clear on next increment
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            count_value[gi] <= `PMT_COUNT_RESET;
            match_pulse[gi] <= 1'b0;
            clear_pending[gi] <= 1'b0;
        end
        else if (dis)
        begin
            count_value[gi] <= `PMT_COUNT_RESET;
            match_pulse[gi] <= 1'b0;
            clear_pending[gi] <= 1'b0;
        end
        else
        begin
            match_pulse[gi] <= 1'b0;
            if (wr_cnt)
            begin
                count_value[gi] <= wdat;
                clear_pending[gi] <= 1'b0;
            end
            else if (inc)
            begin
                if (clear_pending[gi])
                    count_value[gi] <= 8'h00;
                else
                    count_value[gi] <= count_value[gi] + 8'h01;
                clear_pending[gi] <= 1'b0;
                if (!clear_pending[gi] && (count_value[gi] + 8'h01) == period_value[gi])
                begin
                    clear_pending[gi] <= 1'b1;
                    match_pulse[gi] <= 1'b1;
                end
            end
            else if (tick && is_match && !clear_pending[gi] && pre_done)
                clear_pending[gi] <= 1'b1;
        end
    end
end
endgenerate

// ------------------------------------------------------------
// Interrupt flags: set wins over read clear
// ------------------------------------------------------------
reg [NUM_TIMERS-1:0] next_flag;

// Read clear first, then new events set
always @*
begin
    next_flag = rd_status ? {NUM_TIMERS{1'b0}} : match_irq_flag;
    next_flag = next_flag | post_event;
end

always @(posedge clk or posedge reset)
begin
    if (reset)
        match_irq_flag <= {NUM_TIMERS{1'b0}};
    else
        match_irq_flag <= next_flag;
end

wire [NUM_TIMERS-1:0] pend = match_irq_flag & match_irq_enable;
assign irq = |pend;
assign irq_high = |(pend & match_irq_priority);
assign irq_low = |(pend & ~match_irq_priority);

// ------------------------------------------------------------
// Time base outputs
// ------------------------------------------------------------
integer ci;
always @*
begin
    for (ci = 0; ci < CCP_UNITS; ci = ci + 1)
    begin
        case (timebase_select[2*ci +: 2])
            2'h0: ccp_timebase[ci] = match_pulse[0];
            2'h1: ccp_timebase[ci] = match_pulse[1 % NUM_TIMERS];
            2'h2: ccp_timebase[ci] = match_pulse[2 % NUM_TIMERS];
            default: ccp_timebase[ci] = 1'b0;
        endcase
    end
end

wire spi_mode = (sys_ctrl[`PMT_SYS_MODE_MSB:`PMT_SYS_MODE_LSB] == `PMT_SPI_TIMER_CODE);
assign serial_shift_clock = spi_mode && match_pulse[0];

// ------------------------------------------------------------
// Read data
// ------------------------------------------------------------
integer ri;
always @*
begin
    hrdata = 32'h00000000;
    if (is_reg(acc_addr, `PMT_OFF_STATUS))
        hrdata[NUM_TIMERS-1:0] = match_irq_flag;
    else if (is_reg(acc_addr, `PMT_OFF_MASK))
        hrdata[NUM_TIMERS-1:0] = match_irq_enable;
    else if (is_reg(acc_addr, `PMT_OFF_PRIORITY))
        hrdata[NUM_TIMERS-1:0] = match_irq_priority;
    else if (is_reg(acc_addr, `PMT_OFF_DISABLE))
        hrdata[NUM_TIMERS-1:0] = module_disable;
    else if (is_reg(acc_addr, `PMT_OFF_SYSCTL))
        hrdata[7:0] = sys_ctrl;
    for (ri = 0; ri < NUM_TIMERS; ri = ri + 1)
    begin
        if (is_reg(acc_addr, inst_base(ri) + `PMT_OFF_COUNT))
            hrdata[7:0] = count_value[ri];
        if (is_reg(acc_addr, inst_base(ri) + `PMT_OFF_PERIOD))
            hrdata[7:0] = period_value[ri];
        if (is_reg(acc_addr, inst_base(ri) + `PMT_OFF_CONTROL))
            hrdata[7:0] = timer_control[ri];
    end
    if (!rd_pend)
        hrdata = 32'h00000000;
end

endmodule

// File: pmt_defs.vh
// Register map, field positions, reset values and timing constants of the timer block
`ifndef PMT_DEFS_VH
`define PMT_DEFS_VH

// ------------------------------------------------------------
// Register byte offsets per instance (instance base = n * 0x20)
// ------------------------------------------------------------
`define PMT_INST_STRIDE 8'h20
`define PMT_OFF_COUNT 8'h00
`define PMT_OFF_PERIOD 8'h04
`define PMT_OFF_CONTROL 8'h08
// Shared registers
`define PMT_OFF_STATUS 8'h60
`define PMT_OFF_MASK 8'h64
`define PMT_OFF_PRIORITY 8'h68
`define PMT_OFF_DISABLE 8'h6c
`define PMT_OFF_SYSCTL 8'h70

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define PMT_CKPS_LSB 0
`define PMT_CKPS_MSB 1
`define PMT_RUN_BIT 2
`define PMT_OUTPS_LSB 3
`define PMT_OUTPS_MSB 6
`define PMT_CTRL_MASK 8'h7f

// System control fields: sleep bit and serial port mode field
`define PMT_SYS_SLEEP_BIT 0
`define PMT_SYS_MODE_LSB 4
`define PMT_SYS_MODE_MSB 7
`define PMT_SPI_TIMER_CODE 4'h3

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define PMT_COUNT_RESET 8'h00
`define PMT_PERIOD_RESET 8'hff
`define PMT_CONTROL_RESET 8'h00
`define PMT_PRE_DIV4_LAST 4'h3
`define PMT_PRE_DIV16_LAST 4'hf
`define PMT_INSTR_DIV 2'h3

`endif

// File: pmt_checker.sv
// Port assertions for the three-timer block
`timescale 1ns/1ps
module pmt_checker #(
    parameter CCP_UNITS = 5
)(
    input wire clk,
    input wire reset,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [2*CCP_UNITS-1:0] timebase_select,
    input wire [CCP_UNITS-1:0] ccp_timebase,
    input wire serial_shift_clock,
    input wire irq,
    input wire irq_high,
    input wire irq_low
);
    reg data_phase;
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            data_phase <= 1'b0;
        else
            data_phase <= hsel && hready && htrans[1];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence addr_rd;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence pulse_gap;
        !ccp_timebase[0] [*3];
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    read_upper_a: assert property (addr_rd |=> hrdata[31:8] == 24'h0) else $error("upper read bits set");
    idle_data_a: assert property (!data_phase |-> hrdata == 32'h0) else $error("read data outside data phase");
    match_pulse_a: assert property (ccp_timebase[0] |=> pulse_gap) else $error("match pulse too close");
    irq_split_a: assert property (irq == (irq_high || irq_low)) else $error("irq split wrong");
    reset_quiet_a: assert property ($fell(reset) |-> !irq && !ccp_timebase[0]) else $error("activity after reset");
    spi_clock_a: assert property ((timebase_select[1:0] == 2'h0 && serial_shift_clock) |-> ccp_timebase[0])
        else $error("shift clock without match");
    unit_alias_a: assert property ((timebase_select[1:0] == 2'h0 && timebase_select[7:6] == 2'h3)
        |-> !ccp_timebase[3]) else $error("time base select wrong");
endmodule
bind pmt_timer pmt_checker #(.CCP_UNITS(CCP_UNITS)) chk_u (.clk(clk), .reset(reset), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .timebase_select(timebase_select), .ccp_timebase(ccp_timebase),
    .serial_shift_clock(serial_shift_clock), .irq(irq), .irq_high(irq_high), .irq_low(irq_low));

// File: pmt_ccp_model.sv
// Capture/compare/PWM side: picks time bases and counts unit 0 pulses
`timescale 1ns/1ps
module pmt_ccp_model #(
    parameter CCP_UNITS = 5
)(
    input wire clk,
    input wire reset,
    input wire [CCP_UNITS-1:0] ccp_timebase,
    output wire [2*CCP_UNITS-1:0] timebase_select,
    output reg [7:0] pulse_count
);
    // Units 0..4 take timers 0,1,2, unused code 3 (no time base), 1
    assign timebase_select = 10'h1e4;
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            pulse_count <= 8'h00;
        else if (ccp_timebase[0])
            pulse_count <= pulse_count + 8'h01;
    end
endmodule

// File: pmt_timer_bench.sv
// Register-level tests of the timer block
`timescale 1ns/1ps
`include "pmt_defs.vh"
module pmt_timer_bench;
    reg clk = 1'b0;
    reg reset = 1'b1;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, sclk, irq, irq_high, irq_low;
    wire [9:0] tsel;
    wire [4:0] ccp;
    wire [7:0] pulses;
    reg [31:0] rd;
    reg [7:0] p0;
    integer num_errors = 0;
    integer checks_done = 0;
    integer n, c;
    always #25 clk = ~clk;
    pmt_timer dut_u (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .timebase_select(tsel), .ccp_timebase(ccp), .serial_shift_clock(sclk),
        .irq(irq), .irq_high(irq_high), .irq_low(irq_low));
    pmt_ccp_model ccp_u (.clk(clk), .reset(reset), .ccp_timebase(ccp), .timebase_select(tsel),
        .pulse_count(pulses));
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task check(input [63:0] what, input [31:0] seen, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("unexpected %0s: expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task bus(input wr, input [7:0] a, input [31:0] d);
    begin
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    end
    endtask
    task spacing(input integer u);
    begin
        c = 0;
        while (ccp[u] !== 1'b1 && c < 2000) begin @(posedge clk); c = c + 1; end
        c = 0;
        @(posedge clk);
        while (ccp[u] !== 1'b1 && c < 2000) begin @(posedge clk); c = c + 1; end
        c = c + 1;
    end
    endtask
    task hold(input [7:0] a);
    begin
        bus(0, a, 0);
        p0 = rd[7:0];
        repeat (40) @(posedge clk);
        bus(0, a, 0);
        check("hold", rd, {24'h0, p0});
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        #2000000;
        num_errors = num_errors + 1;
        end_of_test;
    end
    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (n = 0; n < 3; n = n + 1)
        begin
            bus(0, {n[2:0], 5'h00}, 0); check("count", rd, 32'h0);
            bus(0, {n[2:0], 5'h04}, 0); check("period", rd, 32'hff);
            bus(0, {n[2:0], 5'h08}, 0); check("control", rd, 32'h0);
        end
        bus(0, 8'h7c, 0); check("unmapped", rd, 32'h0);
        bus(1, `PMT_OFF_CONTROL, 32'hff); bus(0, `PMT_OFF_CONTROL, 0); check("ctl", rd, 32'h7f);
        bus(1, `PMT_OFF_CONTROL, 32'h0);
        bus(1, `PMT_OFF_COUNT, 32'h55);
        bus(1, `PMT_OFF_CONTROL, 32'h06);
        bus(0, `PMT_OFF_COUNT, 0); check("keep", rd, 32'h55);
        bus(1, `PMT_OFF_CONTROL, 32'h02);
        hold(`PMT_OFF_COUNT);
        bus(1, `PMT_OFF_PERIOD, 32'h3); bus(0, `PMT_OFF_PERIOD, 0); check("period", rd, 32'h3);
        bus(1, `PMT_OFF_COUNT, 32'h0);
        for (n = 0; n < 4; n = n + 1)
        begin
            bus(1, `PMT_OFF_CONTROL, 32'h04 | n);
            spacing(0); check("gap", c, n == 0 ? 16 : (n == 1 ? 64 : 256));
        end
        bus(1, 8'h24, 32'h1);
        bus(1, 8'h28, 32'h4);
        spacing(1); check("gap1", c, 8);
        bus(1, `PMT_OFF_CONTROL, 32'h0);
        bus(0, `PMT_OFF_STATUS, 0);
        bus(1, `PMT_OFF_MASK, 32'h1);
        p0 = pulses;
        bus(1, `PMT_OFF_CONTROL, 32'h14);
        c = 0;
        while (irq !== 1'b1 && c < 500) begin @(posedge clk); c = c + 1; end
        check("matches", {24'h0, pulses - p0}, 32'h3);
        bus(0, `PMT_OFF_STATUS, 0); check("flag", {31'h0, rd[0]}, 32'h1);
        @(posedge clk); check("irq", {31'h0, irq}, 32'h0);
        bus(1, `PMT_OFF_MASK, 32'h0);
        repeat (60) @(posedge clk);
        check("masked", {31'h0, irq}, 32'h0);
        bus(1, `PMT_OFF_PRIORITY, 32'h1);
        bus(1, `PMT_OFF_MASK, 32'h1);
        @(posedge clk); check("prio", {30'h0, irq_high, irq_low}, 32'h2);
        bus(1, `PMT_OFF_SYSCTL, 32'h0);
        c = 0;
        repeat (40) begin @(posedge clk); if (sclk === 1'b1) c = c + 1; end
        check("noshift", c, 0);
        bus(1, `PMT_OFF_SYSCTL, 32'h30);
        c = 0;
        while (sclk !== 1'b1 && c < 100) begin @(posedge clk); c = c + 1; end
        check("shift", {31'h0, sclk}, 32'h1);
        bus(1, `PMT_OFF_SYSCTL, 32'h31);
        hold(`PMT_OFF_COUNT);
        bus(1, `PMT_OFF_SYSCTL, 32'h0);
        bus(1, `PMT_OFF_DISABLE, 32'h1);
        bus(0, `PMT_OFF_PERIOD, 0); check("dis_per", rd, 32'hff);
        bus(0, `PMT_OFF_COUNT, 0); check("dis_cnt", rd, 32'h0);
        end_of_test;
    end
endmodule
